// file: logic/mgp_pkg.sv
// package: constants and types for the masked pin command port
package mgp_pkg;
  localparam int unsigned mgp_low_pins = 8;
  localparam int unsigned mgp_up_pins = 4;
  // command codes on the write port address
  localparam logic [2:0] mgp_cmd_live_dir = 3'h0;
  localparam logic [2:0] mgp_cmd_live_val = 3'h1;
  localparam logic [2:0] mgp_cmd_store_dir = 3'h2;
  localparam logic [2:0] mgp_cmd_store_val = 3'h3;
  localparam logic [2:0] mgp_cmd_upper = 3'h4;
  localparam logic [2:0] mgp_cmd_flag = 3'h5;
  localparam logic [2:0] mgp_cmd_status = 3'h6;
  // word field positions
  localparam int unsigned mgp_mask_lsb = 8;
  localparam int unsigned mgp_val_lsb = 0;
  // pin numbers of reserved pins
  localparam int unsigned mgp_status_a_bit = 2;
  localparam int unsigned mgp_role_bit = 3;
  localparam int unsigned mgp_freset_bit = 4;
  localparam int unsigned mgp_status_b_bit = 5;
  localparam int unsigned mgp_auto_bit = 6;
  // reset and factory values
  localparam logic [7:0] mgp_live_rst = 8'h00;
  localparam logic [7:0] mgp_factory_dir = 8'h00;
  localparam logic [7:0] mgp_factory_val = 8'h00;
  localparam logic [7:0] mgp_factory_flag = 8'h00;
  localparam logic [7:0] mgp_flag_no_sense = 8'h04;
  localparam int unsigned mgp_freset_toggles = 3;
  // factory reset arm window, 1 s at 100 MHz
  localparam int unsigned mgp_clk_mhz = 100;
  localparam int unsigned mgp_arm_ms = 1000;
  localparam int unsigned mgp_arm_cycles = mgp_arm_ms * 1000 * mgp_clk_mhz;
  typedef enum logic [2:0] {
    mgp_st_load = 3'h1,
    mgp_st_run = 3'h2,
    mgp_st_wipe = 3'h4
  } mgp_state_t;
endpackage

// file: logic/mgp_store_if.sv
// interface: port between the core and the stored settings
`timescale 1ns/10ps
interface mgp_store_if;
  logic [7:0] dir;
  logic [7:0] val;
  logic [7:0] flag;
  logic wr_dir;
  logic wr_val;
  logic wr_flag;
  logic [15:0] word;
  logic wipe;
  modport core (input dir, val, flag, output wr_dir, wr_val, wr_flag, word,
    wipe);
  modport store (output dir, val, flag, input wr_dir, wr_val, wr_flag, word,
    wipe);
endinterface

// file: logic/mgp_store.sv
// module: stored power-up direction, value and flag words
`timescale 1ns/10ps
module mgp_store
  import mgp_pkg::*;
(
  input wire logic clock,
  mgp_store_if.store st
);
  // holds its content across rst; power-up (initial) and wipe load the factory values
  logic [7:0] dir = mgp_factory_dir;
  logic [7:0] val = mgp_factory_val;
  logic [7:0] flag = mgp_factory_flag;
  wire [7:0] wmask = st.word[mgp_mask_lsb +: 8];
  wire [7:0] wval = st.word[mgp_val_lsb +: 8];
  wire [7:0] next_dir = (dir & ~wmask) | (wval & wmask);
  wire [7:0] next_val = (val & ~wmask) | (wval & wmask);

  always_ff @(posedge clock)
  begin
    if (st.wipe)
    begin
      dir <= mgp_factory_dir;
      val <= mgp_factory_val;
      flag <= mgp_factory_flag;
    end
    else
    begin
      if (st.wr_dir)
        dir <= next_dir;
      if (st.wr_val)
        val <= next_val;
      if (st.wr_flag)
        flag <= wval;
    end
  end

  assign st.dir = dir;
  assign st.val = val;
  assign st.flag = flag;
endmodule

// file: logic/mgp_core.sv
// module: masked command pin port with reserved pin handling
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// - each command word except the flag word: high byte selects pins, low byte gives values
// - pins whose mask bit is zero keep their state
// - live direction write; value bit one makes the pin an output
// - value bit drives outputs, enables weak pull-up on inputs
// - live writes act at once and are lost at reset
// - masked write updates stored power-up direction
// - masked write updates stored power-up value
// - upper word drives pins 8 to 11 using low four bits only
// - first upper write turns all four upper pins to outputs
// - upper pins have no stored power-up state
// - factory pin high at power-up then three toggles restores defaults
// - status pins driven internally while outputs; user value overridden
// - role and discovery pins sampled at power-up unless flag is four
module mgp_core
  import mgp_pkg::*;
#(
  parameter int unsigned arm_cycles = mgp_arm_cycles
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pull_up_en,
  output logic [3:0] upper_out,
  output logic [3:0] upper_oe_n,
  input wire logic status_a,
  input wire logic status_b,
  output logic master_mode,
  output logic auto_discovery,
  output logic factory_reset_done
);
  mgp_store_if st ();

  mgp_store u_store (
    .clock(clock),
    .st(st)
  );

  function automatic logic [7:0] masked(input logic [7:0] old,
    input logic [15:0] w);
    masked = (old & ~w[mgp_mask_lsb +: 8]) | (w[mgp_val_lsb +: 8] &
      w[mgp_mask_lsb +: 8]);
  endfunction

  mgp_state_t state;
  mgp_state_t next_state;
  logic [7:0] live_dir;
  logic [7:0] live_val;
  logic [3:0] up_val;
  logic up_on;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic fr_prev;
  logic fr_armed;
  logic [1:0] fr_count;
  logic [26:0] arm_cnt;
  logic sampled;

  // pin inputs pass two flops before use; no reset here, so the pair
  // already holds real pin levels when the load cycle samples them
  always_ff @(posedge clock)
  begin
    sync1 <= pin_in;
    sync2 <= sync1;
  end

  wire wr_live_dir = wr && addr == mgp_cmd_live_dir;
  wire wr_live_val = wr && addr == mgp_cmd_live_val;
  wire wr_upper = wr && addr == mgp_cmd_upper;
  wire fr_pin = sync2[mgp_freset_bit];
  wire fr_edge = fr_pin != fr_prev;
  wire arm_open = arm_cnt < 27'(arm_cycles);
  wire fr_fire = fr_armed && fr_edge &&
    fr_count == 2'(mgp_freset_toggles - 1);
  wire sense_ok = st.flag != mgp_flag_no_sense;

  assign st.word = wdata;
  assign st.wr_dir = wr && addr == mgp_cmd_store_dir && state == mgp_st_run;
  assign st.wr_val = wr && addr == mgp_cmd_store_val && state == mgp_st_run;
  assign st.wr_flag = wr && addr == mgp_cmd_flag && state == mgp_st_run;
  assign st.wipe = state == mgp_st_wipe;

  always_comb
  begin
    next_state = state;
    case (state)
      mgp_st_load: next_state = mgp_st_run;
      mgp_st_run: if (fr_fire) next_state = mgp_st_wipe;
      mgp_st_wipe: next_state = mgp_st_load;
      default: next_state = mgp_st_load;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= mgp_st_load;
    else
      state <= next_state;
  end

  // live registers: inputs, no pull-up until load; lost on reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      live_dir <= mgp_live_rst;
      live_val <= mgp_live_rst;
    end
    else if (state == mgp_st_load)
    begin
      live_dir <= st.dir;
      live_val <= st.val;
    end
    else
    begin
      if (wr_live_dir)
        live_dir <= masked(live_dir, wdata);
      if (wr_live_val)
        live_val <= masked(live_val, wdata);
    end
  end

  // upper pins: no stored copy, outputs from the first write on
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      up_val <= 4'h0;
      up_on <= 1'b0;
    end
    else if (wr_upper)
    begin
      up_on <= 1'b1;
      up_val <= (up_val & ~wdata[mgp_mask_lsb +: 4]) |
        (wdata[mgp_val_lsb +: 4] & wdata[mgp_mask_lsb +: 4]);
    end
  end

  // factory pin: armed if high at end of load, counts edges in window;
  // the window bounds how late a user may trigger the restore
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fr_prev <= 1'b0;
      fr_armed <= 1'b0;
      fr_count <= 2'h0;
      arm_cnt <= 27'h0;
      sampled <= 1'b0;
    end
    else
    begin
      fr_prev <= fr_pin;
      if (arm_open)
        arm_cnt <= arm_cnt + 27'h1;
      if (state == mgp_st_load && !sampled)
      begin
        sampled <= 1'b1;
        fr_armed <= fr_pin;
      end
      else if (fr_fire || !arm_open)
        fr_armed <= 1'b0;
      else if (fr_armed && fr_edge)
        fr_count <= fr_count + 2'h1;
    end
  end

  wire [7:0] drive_val = {live_val[7:6],
    status_b, live_val[4:3], status_a, live_val[1:0]};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= 8'h00;
      pin_oe_n <= 8'hFF;
      pull_up_en <= 8'h00;
      upper_out <= 4'h0;
      upper_oe_n <= 4'hF;
      master_mode <= 1'b0;
      auto_discovery <= 1'b0;
      factory_reset_done <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      pin_out <= drive_val & live_dir;
      pin_oe_n <= ~live_dir;
      pull_up_en <= live_val & ~live_dir;
      upper_out <= up_val;
      upper_oe_n <= {4{~up_on}};
      factory_reset_done <= factory_reset_done | st.wipe;
      if (state == mgp_st_load && !sampled && sense_ok)
      begin
        master_mode <= sync2[mgp_role_bit];
        auto_discovery <= sync2[mgp_auto_bit];
      end
      if (rd)
        case (addr)
          mgp_cmd_live_dir: rdata <= {8'h00, live_dir};
          mgp_cmd_live_val: rdata <= {8'h00, live_val};
          mgp_cmd_store_dir: rdata <= {8'h00, st.dir};
          mgp_cmd_store_val: rdata <= {8'h00, st.val};
          mgp_cmd_upper: rdata <= {11'h000, up_on, up_val};
          mgp_cmd_flag: rdata <= {8'h00, st.flag};
          mgp_cmd_status: rdata <= {8'h00, sync2};
          default: rdata <= 16'h0000;
        endcase
      else
        rdata <= 16'h0000;
    end
  end

  live_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_live_dir && state == mgp_st_run |=> live_dir ==
      masked($past(live_dir), $past(wdata)))
    else $error("live direction write wrong");
  keep_unmasked_a: assert property (@(posedge clock) disable iff (rst)
    wr_live_val && state == mgp_st_run |=> ((live_val ^ $past(live_val)) &
      ~$past(wdata[15:8])) == 8'h00)
    else $error("unmasked value bit changed");
  oe_follows_a: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> pin_oe_n == ~$past(live_dir))
    else $error("output enable not following direction");
  pull_up_a: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pull_up_en & ~pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  upper_on_a: assert property (@(posedge clock) disable iff (rst)
    wr_upper |=> ##1 upper_oe_n == 4'h0 ##1 upper_oe_n == 4'h0)
    else $error("upper pins not outputs after write");
  status_a_a: assert property (@(posedge clock) disable iff (rst)
    live_dir[mgp_status_a_bit] |=> pin_out[mgp_status_a_bit] ==
      $past(status_a))
    else $error("status pin a not overridden");
  sequence wipe_s;
    state == mgp_st_wipe ##1 state == mgp_st_load;
  endsequence
  restore_a: assert property (@(posedge clock) disable iff (rst)
    fr_fire && state == mgp_st_run |=> wipe_s ##1 st.dir ==
      mgp_factory_dir)
    else $error("factory restore not done");
  load_copy_a: assert property (@(posedge clock) disable iff (rst)
    state == mgp_st_load |=> live_dir == $past(st.dir))
    else $error("stored direction not copied");
  store_write_a: assert property (@(posedge clock) disable iff (rst)
    st.wr_val && !st.wipe |=> st.val == masked($past(st.val),
      $past(wdata)))
    else $error("stored value write wrong");
  reset_in_a: assert property (@(posedge clock)
    $fell(rst) |-> pin_oe_n == 8'hFF && pull_up_en == 8'h00)
    else $error("pins not inputs at reset release");
endmodule

// file: bench/mgp_pin_model.sv
// file: pin-side circuitry model for the masked pin port
`timescale 1ns/10ps
module mgp_pin_model
(
  input wire logic clock,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_lvl,
  output logic [7:0] pin_in
);
  logic [7:0] float_q = 8'h55;
  // an open pin flips every cycle so no stale level can pass for a drive
  always @(posedge clock)
    float_q <= ~float_q;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_lvl[i];
      else if (pull_up_en[i])
        pin_in[i] = 1'h1;
      else
        pin_in[i] = float_q[i];
    end
  end
endmodule

// file: bench/masked_gpio_command_port_bench.sv
// file: self-checking bench for the masked pin command port
`timescale 1ns/10ps
module masked_gpio_command_port_bench
  import mgp_pkg::*;
;
  typedef struct {
    logic [2:0] a;
    logic [15:0] w;
    logic sa;
    logic sb;
  } mgp_row_t;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic status_a = 1'h0;
  logic status_b = 1'h0;
  // factory pin held low, role and discovery pins held high
  logic [7:0] ext_en = 8'h58;
  logic [7:0] ext_lvl = 8'h48;
  logic [15:0] rdata;
  logic [7:0] pin_in, pin_out, pin_oe_n, pull_up_en;
  logic [3:0] upper_out, upper_oe_n;
  logic master_mode, auto_discovery, factory_reset_done;
  logic [7:0] dir = 8'h00;
  logic [7:0] val = 8'h00;
  logic [3:0] uval = 4'h0;
  logic uon = 1'h0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  mgp_row_t rows [11] = '{
    '{mgp_cmd_live_dir, 16'h8080, 1'h0, 1'h0},
    '{mgp_cmd_live_val, 16'h8080, 1'h0, 1'h0},
    '{mgp_cmd_live_val, 16'h8000, 1'h0, 1'h0},
    '{mgp_cmd_live_val, 16'h0303, 1'h0, 1'h0},
    '{mgp_cmd_live_dir, 16'h2424, 1'h1, 1'h0},
    '{mgp_cmd_live_val, 16'h2400, 1'h1, 1'h1},
    '{mgp_cmd_live_dir, 16'h2400, 1'h0, 1'h1},
    '{mgp_cmd_upper, 16'h0101, 1'h0, 1'h0},
    '{mgp_cmd_upper, 16'hF0F2, 1'h0, 1'h0},
    '{mgp_cmd_upper, 16'h0F0A, 1'h0, 1'h0},
    '{mgp_cmd_live_dir, 16'hFF0F, 1'h0, 1'h0}};

  always #5 clock = ~clock;

  mgp_core #(.arm_cycles(50)) i_mgp_core (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pull_up_en(pull_up_en), .upper_out(upper_out),
    .upper_oe_n(upper_oe_n), .status_a(status_a), .status_b(status_b),
    .master_mode(master_mode), .auto_discovery(auto_discovery),
    .factory_reset_done(factory_reset_done));

  mgp_pin_model i_mgp_pin_model (.clock(clock), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  task automatic print_verdict();
    $display("mismatches %0d in %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the run needs under two hundred cycles; far more means a hang
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr_cmd(input logic [2:0] a, input logic [15:0] w);
    @(posedge clock);
    addr <= a;
    wdata <= w;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    chk(rdata, exp, "read data");
    @(posedge clock);
    #1;
    chk(rdata, 16'h0000, "read data not cleared");
  endtask

  task automatic pwr();
    @(posedge clock);
    rst <= 1'h1;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic chk_pins();
    logic [7:0] e_oe;
    logic [7:0] e_pu;
    logic [7:0] e_out;
    e_oe = ~dir;
    e_pu = val & ~dir;
    e_out = val;
    e_out[mgp_status_a_bit] = status_a;
    e_out[mgp_status_b_bit] = status_b;
    chk(pin_oe_n, e_oe, "direction");
    chk(pull_up_en, e_pu, "pull-up");
    chk(pin_out & dir, e_out & dir, "drive level");
    chk(upper_oe_n, uon ? 4'h0 : 4'hF, "upper direction");
    if (uon)
      chk(upper_out, uval, "upper value");
  endtask

  initial
  begin
    logic [7:0] m;
    repeat (5) @(posedge clock);
    #1;
    chk(pin_oe_n, 8'hFF, "reset direction");
    chk(pull_up_en, 8'h00, "reset pull-up");
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    chk_pins();
    chk({master_mode, auto_discovery}, 2'h3, "role sensing");
    $display("test reset done");
    foreach (rows[i])
    begin
      @(posedge clock);
      status_a <= rows[i].sa;
      status_b <= rows[i].sb;
      wr_cmd(rows[i].a, rows[i].w);
      m = rows[i].w[15:8];
      if (rows[i].a == mgp_cmd_live_dir)
        dir = (dir & ~m) | (rows[i].w[7:0] & m);
      else if (rows[i].a == mgp_cmd_live_val)
        val = (val & ~m) | (rows[i].w[7:0] & m);
      else
      begin
        uval = (uval & ~m[3:0]) | (rows[i].w[3:0] & m[3:0]);
        uon = 1'h1;
      end
      repeat (2) @(posedge clock);
      #1;
      chk_pins();
    end
    $display("test command rows done");
    rd_chk(mgp_cmd_live_dir, {8'h00, dir});
    rd_chk(3'h7, 16'h0000);
    $display("test reads done");
    wr_cmd(mgp_cmd_store_dir, 16'h0101);
    wr_cmd(mgp_cmd_store_val, 16'h0303);
    wr_cmd(mgp_cmd_flag, 16'hFF04);
    pwr();
    dir = 8'h01;
    val = 8'h03;
    uon = 1'h0;
    chk_pins();
    chk({master_mode, auto_discovery}, 2'h0, "sensing suppressed");
    $display("test stored settings done");
    ext_lvl[mgp_freset_bit] <= 1'h1;
    pwr();
    repeat (3)
    begin
      repeat (4) @(posedge clock);
      ext_lvl[mgp_freset_bit] <= ~ext_lvl[mgp_freset_bit];
    end
    repeat (20) @(posedge clock);
    #1;
    chk(factory_reset_done, 1'h1, "factory restore");
    dir = mgp_factory_dir;
    val = mgp_factory_val;
    chk_pins();
    ext_lvl[mgp_freset_bit] <= 1'h0;
    pwr();
    chk_pins();
    chk({master_mode, auto_discovery}, 2'h3, "flag restored");
    $display("test factory restore done");
    print_verdict();
  end
endmodule
